// >>> inc/mled_pkg.sv
// constants shared by the display serial link ends
// Overview of operation
// - ignore clock and data while select high
// - word is command byte then data byte
// - data reappears on output 15.5 clocks later
// - chain needs 16 times n clocks
// - shift input on rising clock, select low
// - select rise latches word and executes
// - host shifts msb first, raises select high
// - bit 15 low means write
// - keep last sixteen bits of any frame
// - bit 15 high means read, data dummy
// - read loads register into low byte
// - host reads second byte next frame
// - two planes of four digit bytes
// - blink off shows primary plane only
// - blink on alternates planes per phase
// - low seven bits index font
// - bit seven inverts font pattern
// - blinking continues without host
// - blank code on other plane blinks
// - blink period from mux clock, rate bit
// - digit codes 0x20, 0x40, 0x60 both
// - blink enable is config bit 3
// - blink rate is config bit 2
package mled_pkg;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned DIGITS        = 4;
  localparam logic [6:0]  CMD_NOOP      = 7'h00;
  localparam logic [6:0]  CMD_CONFIG    = 7'h04;
  localparam logic [1:0]  PLANE_PRIMARY = 2'h1;
  localparam logic [1:0]  PLANE_ALT     = 2'h2;
  localparam logic [1:0]  PLANE_BOTH    = 2'h3;
  localparam int unsigned CFG_BLINK_EN  = 3;
  localparam int unsigned CFG_RATE      = 2;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  DIGIT_RESET   = 8'h20;
  // mux clock rising edges per blink phase
  localparam logic [15:0] BLINK_SLOW    = 16'h0100;
  localparam logic [15:0] BLINK_FAST    = 16'h0080;
  // host divider: pclk cycles per link clock half period
  localparam logic [3:0]  HALF_PERIOD   = 4'h8;
  // link clock rises per frame of one device
  localparam logic [4:0]  FRAME_BITS    = 5'h10;
  // host register offsets: word to send, status and last received word
  localparam logic [11:0] ADDR_TX       = 12'h000;
  localparam logic [11:0] ADDR_RX       = 12'h004;
endpackage

// >>> inc/mled_if.sv
// serial link between host and display driver
`timescale 1ns/1ps
interface mled_if;
  logic select_n;
  logic sclk;
  logic sdin;
  logic sdout;
  modport device (input select_n, input sclk, input sdin, output sdout);
  modport host (output select_n, output sclk, output sdin, input sdout);
endinterface

// >>> logic/mled_device.sv
// display driver end: serial decode, digit planes, blink, font index and invert outputs
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mled_device (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link
  mled_if.device           link,
  // multiplex clock pin
  input  wire logic        multiplex_clock_input,
  // display scan
  input  wire logic [1:0]  scan_digit,
  output logic      [7:0]  scan_code,
  output logic      [6:0]  font_index,
  output logic             font_invert,
  output logic             blink_phase,
  output logic      [7:0]  config_value
);
  typedef struct packed {
    logic [1:0]  s_cs;
    logic [1:0]  s_ck;
    logic [1:0]  s_di;
    logic [1:0]  s_mx;
    logic        ck_d;
    logic        cs_d;
    logic        mx_d;
    logic [15:0] shift;
    logic [15:0] latch;
    logic        exec;
    logic        dout;
    logic [7:0]  cfg;
    logic [3:0][7:0] primary_plane;
    logic [3:0][7:0] alternate_plane;
    logic [15:0] blink_cnt;
    logic        phase;
    logic [7:0]  code;
  } state_t;
  state_t r;
  state_t next_r;

  // digit plane mask of a command code: bit 0 primary, bit 1 alternate
  function automatic logic [1:0] plane_sel(input logic [6:0] a);
    logic [1:0] m;
    m = 2'b00;
    if (a[4:2] == 3'h0)
      m = a[6:5];
    return m;
  endfunction

  // register read decode
  function automatic logic [7:0] read_reg(input state_t s,
                                           input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == mled_pkg::CMD_CONFIG)
      v = s.cfg;
    else if (plane_sel(a) == mled_pkg::PLANE_PRIMARY)
      v = s.primary_plane[a[1:0]];
    else if (plane_sel(a) == mled_pkg::PLANE_ALT)
      v = s.alternate_plane[a[1:0]];
    return v;
  endfunction

  logic        ck_rise;
  logic        ck_fall;
  logic        cs_rise;
  logic        mx_rise;
  logic [15:0] word;
  logic [1:0]  planes;

  always_comb begin
    next_r = r;
    next_r.s_cs = {r.s_cs[0], link.select_n};
    next_r.s_ck = {r.s_ck[0], link.sclk};
    next_r.s_di = {r.s_di[0], link.sdin};
    next_r.s_mx = {r.s_mx[0], multiplex_clock_input};
    next_r.ck_d = r.s_ck[1];
    next_r.cs_d = r.s_cs[1];
    next_r.mx_d = r.s_mx[1];
    ck_rise = r.s_ck[1] & ~r.ck_d & ~r.s_cs[1];
    ck_fall = ~r.s_ck[1] & r.ck_d & ~r.s_cs[1];
    cs_rise = r.s_cs[1] & ~r.cs_d;
    mx_rise = r.s_mx[1] & ~r.mx_d;
    word = r.latch;
    planes = plane_sel(word[14:8]);
    if (ck_rise)
      next_r.shift = {r.shift[14:0], r.s_di[1]};
    if (ck_fall)
      next_r.dout = r.shift[15];
    // latch on the select edge, execute from the latch one cycle later
    next_r.exec = cs_rise;
    if (cs_rise)
      next_r.latch = r.shift;
    if (r.exec) begin
      if (!word[15]) begin
        if (word[14:8] == mled_pkg::CMD_CONFIG)
          next_r.cfg = word[7:0];
        if (planes[0])
          next_r.primary_plane[word[9:8]] = word[7:0];
        if (planes[1])
          next_r.alternate_plane[word[9:8]] = word[7:0];
      end else begin
        next_r.shift[7:0] = read_reg(r, word[14:8]);
      end
    end
    if (!r.cfg[mled_pkg::CFG_BLINK_EN]) begin
      next_r.phase = 1'b0;
      next_r.blink_cnt = 16'h0000;
    end else if (mx_rise) begin
      if (r.blink_cnt >= (r.cfg[mled_pkg::CFG_RATE] ?
          mled_pkg::BLINK_FAST : mled_pkg::BLINK_SLOW) - 16'h0001) begin
        next_r.blink_cnt = 16'h0000;
        next_r.phase = ~r.phase;
      end else begin
        next_r.blink_cnt = r.blink_cnt + 16'h0001;
      end
    end
    next_r.code = r.phase ? r.alternate_plane[scan_digit]
                          : r.primary_plane[scan_digit];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.s_cs <= 2'b11;
      r.cs_d <= 1'b1;
      r.cfg <= mled_pkg::CFG_RESET;
      r.primary_plane <= {4{mled_pkg::DIGIT_RESET}};
      r.alternate_plane <= {4{mled_pkg::DIGIT_RESET}};
    end else begin
      r <= next_r;
    end
  end

  assign link.sdout   = r.dout;
  assign scan_code    = r.code;
  assign font_index   = r.code[6:0];
  assign font_invert  = r.code[7];
  assign blink_phase  = r.phase;
  assign config_value = r.cfg;
endmodule

// >>> logic/mled_host.sv
// host end: APB command registers driving the serial link
`timescale 1ns/1ps
module mled_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  mled_if.host             link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_SHIFT = 3'b010, ST_END = 3'b100
  } st_t;
  typedef struct packed {
    st_t         st;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [1:0]  s_do;
    logic [3:0]  div;
    logic        ck;
    logic        cs_n;
    logic [4:0]  bits;
    logic [31:0] rdata;
  } state_t;
  state_t r;
  state_t next_r;
  logic   acc;

  always_comb begin
    next_r = r;
    acc = psel & penable;
    next_r.s_do = {r.s_do[0], link.sdout};
    // loaded in the setup cycle so that it stands at the access edge
    if (psel && !penable && !pwrite)
      next_r.rdata = (paddr == mled_pkg::ADDR_RX) ?
        {15'h0000, r.st != ST_IDLE, r.rx} : 32'h0000_0000;
    case (r.st)
      ST_IDLE: begin
        next_r.ck = 1'b0;
        if (acc && pwrite && paddr == mled_pkg::ADDR_TX) begin
          next_r.tx = pwdata[15:0];
          next_r.cs_n = 1'b0;
          next_r.bits = mled_pkg::FRAME_BITS;
          next_r.div = mled_pkg::HALF_PERIOD;
          next_r.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        next_r.div = r.div - 4'h1;
        if (r.div == 4'h1) begin
          next_r.div = mled_pkg::HALF_PERIOD;
          if (!r.ck) begin
            next_r.ck = 1'b1;
            next_r.rx = {r.rx[14:0], r.s_do[1]};
            next_r.bits = r.bits - 5'd1;
          end else if (r.bits == 5'd0) begin
            next_r.cs_n = 1'b1;
            next_r.st = ST_END;
          end else begin
            next_r.ck = 1'b0;
            next_r.tx = {r.tx[14:0], 1'b0};
          end
        end
      end
      ST_END: begin
        next_r.div = r.div - 4'h1;
        if (r.div == 4'h1) begin
          next_r.ck = 1'b0;
          next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cs_n <= 1'b1;
      r.div <= 4'h1;
    end else begin
      r <= next_r;
    end
  end

  assign pready        = 1'b1;
  assign pslverr       = 1'b0;
  assign prdata        = r.rdata;
  assign link.select_n = r.cs_n;
  assign link.sclk     = r.ck;
  assign link.sdin     = r.tx[15];
endmodule

// >>> verif/mled_link_sva.sv
// protocol checks on the display serial link
`timescale 1ns/1ps
module mled_link_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sdout
);
  logic [4:0] rises;
  logic       sclk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises  <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (select_n) rises <= 5'h00;
      else if (sclk && !sclk_q) rises <= rises + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SEL_FALL: assert property ($fell(select_n) |-> !sclk)
    else $error("select fell with clock high");
  AST_SEL_RISE: assert property ($rose(select_n) |-> sclk)
    else $error("select rose with clock low");
  AST_COUNT: assert property ($rose(select_n) |-> rises == 5'h10)
    else $error("frame without sixteen clocks");
  AST_IDLE: assert property (select_n && !sclk |=> !sclk)
    else $error("clock moved while deselected");
  AST_END_LOW: assert property ($rose(select_n) |-> ##[1:9] !sclk)
    else $error("clock not returned low");
  AST_HALF: assert property ($fell(sclk) |-> (!sclk) [*8])
    else $error("clock low phase short");
  AST_SDIN: assert property (sclk && $past(sclk) |-> $stable(sdin))
    else $error("data changed with clock high");
  AST_SDOUT: assert property (sclk && $past(sclk, 4) |-> $stable(sdout))
    else $error("output changed with clock high");
  cover property ($rose(select_n));
  cover property ($rose(sdout));
  cover property ($fell(select_n));
endmodule

// >>> verif/test_matrix_led_serial_digit_blink.sv
// system test of host and display ends over the serial link
`timescale 1ns/1ps
`define CHECK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_matrix_led_serial_digit_blink;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        mux = 1'b0;
  logic [1:0]  scan_digit = 2'h0;
  logic [7:0]  scan_code;
  logic [6:0]  font_index;
  logic        font_invert;
  logic        blink_phase;
  logic [15:0] exp_q[$];
  logic [15:0] seen;
  logic [15:0] prev = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [7:0]  pri[4];
  logic [7:0]  alt[4];
  logic [7:0]  cfg = 8'h00;
  logic [6:0]  codes[10] = '{7'h04, 7'h60, 7'h61, 7'h62, 7'h63,
                            7'h20, 7'h21, 7'h40, 7'h41, 7'h07};
  int          err_total = 0;
  int          total_checks = 0;
  int          seed = 123;
  int          n;
  event        seen_ev;
  mled_if link ();
  mled_host mled_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .link(link));
  mled_device mled_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .multiplex_clock_input(mux), .scan_digit(scan_digit),
    .scan_code(scan_code), .font_index(font_index),
    .font_invert(font_invert), .blink_phase(blink_phase),
    .config_value());
  mled_link_sva mled_link_sva_inst (.pclk(pclk), .presetn(presetn),
    .select_n(link.select_n), .sclk(link.sclk), .sdin(link.sdin),
    .sdout(link.sdout));
  always #2.5 pclk = ~pclk;
  always #20 mux = ~mux;
  always @(seen_ev) begin
    logic [15:0] e;
    e = exp_q.pop_front();
    `CHECK("result", e, seen)
  end
  function automatic logic [7:0] rd(input logic [6:0] c);
    case (c[6:2])
      5'h01: return c[1:0] == 2'h0 ? cfg : 8'h00;
      5'h08: return pri[c[1:0]];
      5'h10: return alt[c[1:0]];
      default: return 8'h00;
    endcase
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [15:0] w);
    logic [31:0] q;
    logic [15:0] s;
    // first bit seen is the last bit shifted out in the frame before
    s = prev[15] ? {prev[15:8], rd(prev[14:8])} : prev;
    exp_q.push_back({last[0], s[14:0]});
    last = s;
    apb(1'b1, 12'h000, {16'h0000, w}, q);
    q = 32'h0001_0000;
    while (q[16] !== 1'b0) begin
      apb(1'b0, 12'h004, 32'h0000_0000, q);
      apb(1'b0, 12'h004, 32'h0000_0000, q);
    end
    seen = q[15:0];
    ->seen_ev;
    if (!w[15] && w[14:8] == 7'h04) cfg = w[7:0];
    if (!w[15] && w[14:13] != 2'b00 && w[12:10] == 3'h0) begin
      if (w[13]) pri[w[9:8]] = w[7:0];
      if (w[14]) alt[w[9:8]] = w[7:0];
    end
    prev = w;
  endtask
  task automatic read_all();
    frame({8'h84, 8'($random(seed))});
    frame({8'h87, 8'($random(seed))});
    for (int i = 0; i < 12; i++)
      frame({1'b1, 2'(i / 4 + 1), 3'h0, 2'(i), 8'($random(seed))});
    frame(16'h0000);
  endtask
  task automatic scan(input logic on);
    for (int d = 0; d < 4; d++) begin
      @(posedge pclk);
      scan_digit <= 2'(d);
      repeat (3) @(posedge pclk);
      exp_q.push_back({8'h00, (on && blink_phase) ? alt[d] : pri[d]});
      seen = {8'h00, font_invert, font_index};
      ->seen_ev;
    end
  endtask
  task automatic flip(output int c);
    logic p;
    p = blink_phase;
    c = 0;
    while (blink_phase === p && c < 9000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      pri[i] = 8'h20;
      alt[i] = 8'h20;
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    frame(16'h0000);
    read_all();
    for (int i = 0; i < 10; i++) frame({1'b0, codes[i], 8'($random(seed))});
    read_all();
    frame(16'h2141);
    frame(16'h4120);
    frame(16'h0400);
    scan(1'b0);
    `CHECK("phase", 1'b0, blink_phase)
    frame(16'h040C);
    flip(n);
    scan(1'b1);
    flip(n);
    `CHECK("fast phase", 8, (n + 64) / 128)
    scan(1'b1);
    frame(16'h0408);
    flip(n);
    flip(n);
    `CHECK("slow phase", 16, (n + 64) / 128)
    stop_test();
  end
endmodule
